// ==== inc/power_manager_pkg.sv ====
package power_manager_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_CORE_CLOCK_ENABLE = 8'h00;
   localparam logic [7:0] OFS_CORE_CLOCK_DISABLE = 8'h04;
   localparam logic [7:0] OFS_CORE_CLOCK_STATE = 8'h08;
   localparam logic [7:0] OFS_PERIPH_CLOCK_ENABLE = 8'h10;
   localparam logic [7:0] OFS_PERIPH_CLOCK_DISABLE = 8'h14;
   localparam logic [7:0] OFS_PERIPH_CLOCK_STATE = 8'h18;
   localparam logic [7:0] OFS_CLOCK_GENERATOR_MODE = 8'h20;
   localparam logic [7:0] OFS_POWER_COMMAND = 8'h28;
   localparam logic [7:0] OFS_POWER_MODE_CONFIG = 8'h2c;
   localparam logic [7:0] OFS_POWER_STATUS = 8'h30;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h34;
   localparam logic [7:0] OFS_IRQ_DISABLE = 8'h38;
   localparam logic [7:0] OFS_IRQ_MASK_STATE = 8'h3c;
   localparam logic [7:0] OFS_WAKE_EVENT_INPUTS = 8'h40;
   // ****************************************
   // Field positions and values
   // ****************************************
   localparam int CORE_CLOCK_BIT = 0;
   localparam logic [31:0] PERIPH_VALID_MASK = 32'h0007effc;
   localparam int SHUTDOWN_COMMAND_BIT = 0;
   localparam int WAKE_ACK_COMMAND_BIT = 1;
   localparam int SHUTDOWN_LEVEL_LSB = 0;
   localparam int WAKE_LEVEL_LSB = 2;
   localparam int ALARM_WAKE_ENABLE_BIT = 4;
   localparam int ALARM_SHUTDOWN_ENABLE_BIT = 5;
   localparam int WAKE_EDGE_LSB = 6;
   localparam logic [7:0] POWER_MODE_RESET = 8'h01;
   localparam logic [31:0] CLOCK_GENERATOR_MODE_RESET = 32'h00000000;
   localparam logic [31:0] CLOCK_GENERATOR_MODE_MASK = 32'h3fffff77;
   localparam logic CORE_CLOCK_RESET = 1'b1;
   localparam logic [1:0] LEVEL_TRISTATE = 2'h0;
   localparam logic [1:0] LEVEL_LOW = 2'h1;
   localparam logic [1:0] LEVEL_HIGH = 2'h2;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISING = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ==== src/power_manager.sv ====
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
// Operation
// - Core clock runs after main reset
// - Enabled interrupt restarts stopped core clock
// - Core clock stops after current instruction
// - Stopped core clock leaves DMA running
// - Write one starts/stops core clock
// - Core clock state bit shows gating
// - Per-peripheral write-one enable and disable
// - Peripheral bits at documented positions
// - Disable stops at once, enable resumes
// - Main reset turns peripheral clocks off
// - Peripheral bit equals interrupt source number
// - Shutdown command drives shutdown level
// - Alarm or wake edge restores wake level
// - Levels: tristate, low or high
// - Alarm use shares shutdown control logic
// - Alarm sets, wake edge acknowledges
// - Backup reset gives wake state, tristate
// - Backup reset loads mode value one
// - No internal pull on shutdown pin
// - Acknowledge wins over shutdown command
// - Wake edge codes none/rise/fall/both
// - Alarm shuts down only without alarm wake
module power_manager
   import power_manager_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic backup_arst_n,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic irq_pending,
   input wire logic instr_done,
   input wire logic rtc_alarm,
   input wire logic wake_pin,
   output logic core_clock_on,
   output logic [31:0] periph_clock_on,
   output logic shutdown_pin_out,
   output logic shutdown_pin_oe_n,
   output logic [31:0] clock_generator_mode
);
   import power_manager_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {CORE_RUN, CORE_STOPPING, CORE_STOPPED} core_state_t;

   typedef struct packed {
      core_state_t core_state;
      logic core_clock_on;
      logic [31:0] periph;
      logic [31:0] cgmr;
      logic [31:0] rdata;
   } main_t;

   typedef struct packed {
      logic [7:0] mode;
      logic in_shutdown;
      logic [2:0] wake_sync;
      logic wake_prev;
      logic alarm_prev;
      logic pin_out;
      logic pin_oe_n;
   } backup_t;

   main_t state;
   main_t next_state;
   backup_t bstate;
   backup_t next_bstate;

   // Write-one decode for the core clock; zero bits do nothing
   function automatic logic core_start_req(
      input logic wr,
      input logic [7:0] addr,
      input logic [31:0] data
   );
      logic addressed;
      addressed = wr && (addr == OFS_CORE_CLOCK_ENABLE);
      core_start_req = addressed && data[CORE_CLOCK_BIT];
   endfunction

   function automatic logic core_stop_req(
      input logic wr,
      input logic [7:0] addr,
      input logic [31:0] data
   );
      logic addressed;
      addressed = wr && (addr == OFS_CORE_CLOCK_DISABLE);
      core_stop_req = addressed && data[CORE_CLOCK_BIT];
   endfunction

   // Enable and disable share one path; reserved bits never reach the gates
   function automatic logic [31:0] periph_update(
      input logic [31:0] cur,
      input logic wr,
      input logic [7:0] addr,
      input logic [31:0] data
   );
      logic [31:0] bits;
      bits = data & PERIPH_VALID_MASK;
      periph_update = cur;
      if (wr && (addr == OFS_PERIPH_CLOCK_ENABLE)) begin
         periph_update = cur | bits;
      end
      if (wr && (addr == OFS_PERIPH_CLOCK_DISABLE)) begin
         periph_update = cur & ~bits;
      end
   endfunction

   function automatic logic [31:0] cgmr_update(
      input logic [31:0] cur,
      input logic wr,
      input logic [7:0] addr,
      input logic [31:0] data
   );
      cgmr_update = cur;
      if (wr && (addr == OFS_CLOCK_GENERATOR_MODE)) begin
         cgmr_update = data & CLOCK_GENERATOR_MODE_MASK;
      end
   endfunction

   function automatic logic [7:0] mode_update(
      input logic [7:0] cur,
      input logic wr,
      input logic [7:0] addr,
      input logic [31:0] data
   );
      mode_update = cur;
      if (wr && (addr == OFS_POWER_MODE_CONFIG)) begin
         mode_update = data[7:0];
      end
   endfunction

   function automatic logic [1:0] power_cmd(
      input logic wr,
      input logic [7:0] addr,
      input logic [31:0] data
   );
      power_cmd = 2'h0;
      if (wr && (addr == OFS_POWER_COMMAND)) begin
         power_cmd = {data[WAKE_ACK_COMMAND_BIT], data[SHUTDOWN_COMMAND_BIT]};
      end
   endfunction

   // Alarm wake has precedence over alarm shutdown
   function automatic logic alarm_shuts(
      input logic alarm,
      input logic [7:0] mode
   );
      logic armed;
      armed = mode[ALARM_SHUTDOWN_ENABLE_BIT] && !mode[ALARM_WAKE_ENABLE_BIT];
      alarm_shuts = alarm && armed;
   endfunction

   function automatic logic alarm_wakes(
      input logic alarm,
      input logic [7:0] mode
   );
      alarm_wakes = alarm && mode[ALARM_WAKE_ENABLE_BIT];
   endfunction

   // Acknowledge wins when both land in one cycle
   function automatic logic shutdown_next(
      input logic cur,
      input logic ack,
      input logic shut
   );
      if (ack) begin
         shutdown_next = 1'b0;
      end else if (shut) begin
         shutdown_next = 1'b1;
      end else begin
         shutdown_next = cur;
      end
   endfunction

   // Only the second and third sync stages are compared
   function automatic logic edge_match(
      input logic [1:0] sel,
      input logic rise,
      input logic fall
   );
      case (sel)
         EDGE_RISING: begin
            edge_match = rise;
         end
         EDGE_FALLING: begin
            edge_match = fall;
         end
         EDGE_BOTH: begin
            edge_match = rise || fall;
         end
         default: begin
            edge_match = 1'b0;
         end
      endcase
   endfunction

   function automatic logic [1:0] level_select(
      input logic in_shutdown,
      input logic [7:0] mode
   );
      if (in_shutdown) begin
         level_select = mode[SHUTDOWN_LEVEL_LSB +: 2];
      end else begin
         level_select = mode[WAKE_LEVEL_LSB +: 2];
      end
   endfunction

   // Reserved level code floats, same as tristate; no pull exists
   function automatic logic level_drives(input logic [1:0] level);
      level_drives = (level == LEVEL_LOW) || (level == LEVEL_HIGH);
   endfunction

   // Write-only and out-of-scope offsets read back as zero
   function automatic logic [31:0] read_word(
      input logic [7:0] addr,
      input logic core_on,
      input logic [31:0] periph,
      input logic [31:0] cgmr,
      input logic [7:0] mode,
      input logic in_shutdown,
      input logic wake_now
   );
      case (addr)
         OFS_CORE_CLOCK_STATE: begin
            read_word = {31'h00000000, core_on};
         end
         OFS_PERIPH_CLOCK_STATE: begin
            read_word = periph;
         end
         OFS_CLOCK_GENERATOR_MODE: begin
            read_word = cgmr;
         end
         OFS_POWER_MODE_CONFIG: begin
            read_word = {24'h000000, mode};
         end
         OFS_WAKE_EVENT_INPUTS: begin
            read_word = {30'h00000000, in_shutdown, wake_now};
         end
         default: begin
            read_word = 32'h00000000;
         end
      endcase
   endfunction

   // ****************************************
   // Main reset domain
   // ****************************************
   always_comb begin
      next_state = state;
      if (clk_en) begin
         // Read data stands one cycle only, and holds while frozen
         next_state.rdata = 32'h00000000;
         next_state.cgmr = cgmr_update(state.cgmr, reg_write, reg_addr, reg_wdata);
         // Peripheral gating is direct, so it stops at once and state is kept
         next_state.periph = periph_update(state.periph, reg_write, reg_addr, reg_wdata);
         // Core clock gating waits for the instruction boundary
         case (state.core_state)
            CORE_RUN: begin
               if (core_stop_req(reg_write, reg_addr, reg_wdata)) begin
                  next_state.core_state = CORE_STOPPING;
               end
            end
            CORE_STOPPING: begin
               if (irq_pending || core_start_req(reg_write, reg_addr, reg_wdata)) begin
                  next_state.core_state = CORE_RUN;
               end else if (instr_done) begin
                  next_state.core_state = CORE_STOPPED;
                  next_state.core_clock_on = 1'b0;
               end
            end
            CORE_STOPPED: begin
               if (irq_pending || core_start_req(reg_write, reg_addr, reg_wdata)) begin
                  next_state.core_state = CORE_RUN;
                  next_state.core_clock_on = 1'b1;
               end
            end
            default: begin
               next_state.core_state = CORE_RUN;
               next_state.core_clock_on = 1'b1;
            end
         endcase
         if (reg_read) begin
            next_state.rdata = read_word(reg_addr, state.core_clock_on, state.periph, state.cgmr,
                                         bstate.mode, bstate.in_shutdown, bstate.wake_sync[2]);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state.core_state <= CORE_RUN;
         state.core_clock_on <= CORE_CLOCK_RESET;
         state.periph <= 32'h00000000;
         state.cgmr <= CLOCK_GENERATOR_MODE_RESET;
         state.rdata <= 32'h00000000;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // Battery backup domain
   // ****************************************
   logic [1:0] edge_sel;
   logic wake_rise;
   logic wake_fall;
   logic wake_edge;
   logic alarm_event;
   logic do_ack;
   logic do_shut;
   logic [1:0] level;
   logic [1:0] cmd;

   always_comb begin
      next_bstate = bstate;
      edge_sel = bstate.mode[WAKE_EDGE_LSB +: 2];
      // Only the agreed second and third stages feed the edge logic
      wake_rise = bstate.wake_sync[2] && bstate.wake_sync[1] && !bstate.wake_prev;
      wake_fall = !bstate.wake_sync[2] && !bstate.wake_sync[1] && bstate.wake_prev;
      wake_edge = edge_match(edge_sel, wake_rise, wake_fall);
      alarm_event = rtc_alarm && !bstate.alarm_prev;
      cmd = power_cmd(reg_write, reg_addr, reg_wdata);
      do_ack = wake_edge || alarm_wakes(alarm_event, bstate.mode) || cmd[1];
      do_shut = alarm_shuts(alarm_event, bstate.mode) || cmd[0];
      level = LEVEL_TRISTATE;
      if (clk_en) begin
         next_bstate.wake_sync = {bstate.wake_sync[1:0], wake_pin};
         if (bstate.wake_sync[2] == bstate.wake_sync[1]) begin
            next_bstate.wake_prev = bstate.wake_sync[2];
         end
         next_bstate.alarm_prev = rtc_alarm;
         next_bstate.mode = mode_update(bstate.mode, reg_write, reg_addr, reg_wdata);
         next_bstate.in_shutdown = shutdown_next(bstate.in_shutdown, do_ack, do_shut);
         level = level_select(next_bstate.in_shutdown, next_bstate.mode);
         next_bstate.pin_oe_n = !level_drives(level);
         next_bstate.pin_out = level == LEVEL_HIGH;
      end
   end

   always_ff @(posedge ref_clk or negedge backup_arst_n) begin
      if (!backup_arst_n) begin
         bstate.mode <= POWER_MODE_RESET;
         bstate.in_shutdown <= 1'b0;
         bstate.wake_sync <= 3'h0;
         bstate.wake_prev <= 1'b0;
         bstate.alarm_prev <= 1'b0;
         bstate.pin_out <= 1'b0;
         bstate.pin_oe_n <= 1'b1;
      end else begin
         bstate <= next_bstate;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Peripheral clocks, DMA included, never depend on core gating
   assign core_clock_on = state.core_clock_on;
   assign periph_clock_on = state.periph;
   assign clock_generator_mode = state.cgmr;
   assign reg_rdata = state.rdata;
   assign shutdown_pin_out = bstate.pin_out;
   assign shutdown_pin_oe_n = bstate.pin_oe_n;
endmodule

// ==== bench/power_manager_chk.sv ====
`timescale 1ns/100ps
// ****
// Checker
// ****
module power_manager_chk
   import power_manager_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic irq_pending,
   input wire logic instr_done,
   input wire logic core_clock_on,
   input wire logic [31:0] periph_clock_on
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   wire wr = reg_write && clk_en;
   wire rd = reg_read && clk_en;
   property p_cen; wr && reg_addr == 8'h00 && reg_wdata[0] |=> core_clock_on; endproperty
   a_cen: assert property (p_cen) else $error("core clock not started");
   property p_irq; irq_pending && clk_en |=> core_clock_on; endproperty
   a_irq: assert property (p_irq) else $error("interrupt left core stopped");
   property p_stop; $fell(core_clock_on) |-> $past(instr_done); endproperty
   a_stop: assert property (p_stop) else $error("core stopped mid instruction");
   property p_pen; wr && reg_addr == 8'h10 |=> &(periph_clock_on | ~($past(reg_wdata) & PERIPH_VALID_MASK)); endproperty
   a_pen: assert property (p_pen) else $error("peripheral clock not enabled");
   property p_pdis; wr && reg_addr == 8'h14 |=> (periph_clock_on & $past(reg_wdata)) == 32'h0; endproperty
   a_pdis: assert property (p_pdis) else $error("peripheral clock not stopped");
   property p_resv; (periph_clock_on & ~PERIPH_VALID_MASK) == 32'h0; endproperty
   a_resv: assert property (p_resv) else $error("reserved clock bit set");
   property p_idle; clk_en && !reg_read |=> reg_rdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside read cycle");
   property p_pst; rd && reg_addr == 8'h18 |=> reg_rdata == $past(periph_clock_on); endproperty
   a_pst: assert property (p_pst) else $error("peripheral state read wrong");
   property p_cst; rd && reg_addr == 8'h08 |=> reg_rdata == {31'h0, $past(core_clock_on)}; endproperty
   a_cst: assert property (p_cst) else $error("core state read wrong");
endmodule
bind power_manager power_manager_chk u_chk (.*);

// ==== bench/supply_model.sv ====
`timescale 1ns/100ps
// ****
// Main supply and wake source
// ****
module supply_model (
   input wire logic ref_clk,
   input wire logic drv_out,
   input wire logic drv_oe_n,
   input wire logic wake_lvl,
   output logic wake_pin,
   output logic shd_line
);
   logic last = 1'b0;
   always @(posedge ref_clk) if (!drv_oe_n) last <= drv_out;
   // No pull: a floating line must not pass for a driven level
   assign shd_line = drv_oe_n ? ~last : drv_out;
   assign wake_pin = wake_lvl;
endmodule

// ==== bench/power_manager_test.sv ====
`timescale 1ns/100ps
// ****
// Testbench
// ****
module power_manager_test;
   import power_manager_pkg::*;
   logic ref_clk = 0, arst_n = 0, irq = 0, idone = 0, alarm = 0, wl = 0, rw = 0, rr = 0, brst_n = 0, cen = 1;
   logic [7:0] ra = 0;
   logic [31:0] wd = 0;
   logic [31:0] rdv, pclk, cgm;
   logic core, oe_n, sout, wk, line;
   logic [1:0] s, w;
   logic [2:0] e;
   int errors = 0, tests_run = 0, cyc = 0;
   power_manager u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .backup_arst_n(brst_n), .clk_en(cen),
      .reg_addr(ra), .reg_wdata(wd), .reg_write(rw), .reg_read(rr), .reg_rdata(rdv), .irq_pending(irq),
      .instr_done(idone), .rtc_alarm(alarm), .wake_pin(wk), .core_clock_on(core), .periph_clock_on(pclk),
      .shutdown_pin_out(sout), .shutdown_pin_oe_n(oe_n), .clock_generator_mode(cgm));
   supply_model u_sup (.ref_clk(ref_clk), .drv_out(sout), .drv_oe_n(oe_n), .wake_lvl(wl),
      .wake_pin(wk), .shd_line(line));
   initial forever #5 ref_clk = ~ref_clk;
   task report_and_stop;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Bound the run well above the few hundred cycles needed
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         report_and_stop;
      end
   end
   task cmp(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task pin(input logic [1:0] c);
      if (c == 2'h0) cmp({31'h0, oe_n}, 32'h1);
      else cmp({30'h0, oe_n, line}, {31'h0, c[1]});
   endtask
   task wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      rw <= 1;
      ra <= a;
      wd <= d;
      @(posedge ref_clk);
      rw <= 0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge ref_clk);
      rr <= 1;
      ra <= a;
      @(posedge ref_clk);
      rr <= 0;
      #1 cmp(rdv, x);
   endtask
   task t_reset;
      rd(8'h08, 32'h1);
      rd(8'h18, 32'h0);
      rd(8'h2c, 32'h1);
      pin(2'h0);
      rd(8'h0c, 32'h0);
      cmp(pclk, 32'h0);
      cmp(cgm, 32'h0);
   endtask
   task t_core;
      wr(8'h04, 32'h1);
      wt(3);
      cmp(core, 1);
      @(posedge ref_clk) idone <= 1;
      wt(2);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h0);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h1);
      rd(8'h08, 32'h1);
      wr(8'h04, 32'h1);
      wt(2);
      cmp(core, 0);
      @(posedge ref_clk) irq <= 1;
      wt(2);
      cmp(core, 1);
      @(posedge ref_clk) irq <= 0;
      idone <= 0;
   endtask
   task t_periph;
      wr(8'h10, 32'hffffffff);
      rd(8'h18, PERIPH_VALID_MASK);
      cmp(pclk, PERIPH_VALID_MASK);
      // Peripherals idle here, so stopping is safe
      wr(8'h14, 32'h4);
      wr(8'h14, 32'h0);
      rd(8'h18, PERIPH_VALID_MASK ^ 32'h4);
      wr(8'h10, 32'h4);
      wr(8'h14, 32'hffffffff);
      rd(8'h18, 32'h0);
      cmp(pclk, 32'h0);
   endtask
   task t_freeze;
      // Frozen block must ignore the bus entirely
      @(posedge ref_clk) cen <= 0;
      wr(8'h10, 32'h40);
      cmp(pclk, 32'h0);
      @(posedge ref_clk) cen <= 1;
      wr(8'h10, 32'h40);
      cmp(pclk, 32'h40);
      wr(8'h14, 32'h40);
      cmp(pclk, 32'h0);
   endtask
   task t_cgm;
      wr(8'h20, 32'hffffffff);
      rd(8'h20, CLOCK_GENERATOR_MODE_MASK);
      cmp(cgm, CLOCK_GENERATOR_MODE_MASK);
      rd(8'h30, 32'h0);
      rd(8'h3c, 32'h0);
      wr(8'h20, 32'h0);
      cmp(cgm, 32'h0);
   endtask
   task t_mid_reset;
      wr(8'h10, 32'h4);
      wr(8'h2c, 32'h09);
      @(posedge ref_clk) arst_n <= 0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1;
      #1 cmp(pclk, 32'h0);
      rd(8'h18, 32'h0);
      rd(8'h2c, 32'h09);
      rd(8'h08, 32'h1);
      @(posedge ref_clk) brst_n <= 0;
      repeat (2) @(posedge ref_clk);
      brst_n <= 1;
      rd(8'h2c, 32'h1);
      pin(2'h0);
   endtask
   task t_level;
      for (s = 0; s < 3; s++) for (w = 0; w < 3; w++) begin
         wr(8'h2c, {28'h0, w, s});
         wr(8'h28, 32'h1);
         pin(s);
         wr(8'h28, 32'h2);
         pin(w);
         wr(8'h28, 32'h1);
         wr(8'h28, 32'h3);
         pin(w);
         rd(8'h2c, {28'h0, w, s});
      end
   endtask
   task t_wake;
      for (e = 0; e < 4; e++) begin
         wr(8'h2c, {24'h0, e[1:0], 6'h09});
         wr(8'h28, 32'h1);
         @(posedge ref_clk) wl <= 1;
         wt(8);
         pin(e[0] ? 2'h2 : 2'h1);
         wr(8'h28, 32'h1);
         @(posedge ref_clk) wl <= 0;
         wt(8);
         pin(e[1] ? 2'h2 : 2'h1);
      end
   endtask
   task t_alarm;
      wr(8'h2c, 32'h69);
      wr(8'h28, 32'h2);
      @(posedge ref_clk) alarm <= 1;
      wt(3);
      pin(2'h1);
      @(posedge ref_clk) alarm <= 0;
      wl <= 1;
      wt(8);
      pin(2'h2);
      rd(8'h40, 32'h1);
      wr(8'h2c, 32'h39);
      wr(8'h28, 32'h1);
      @(posedge ref_clk) alarm <= 1;
      wt(3);
      pin(2'h2);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1;
      brst_n <= 1;
      t_reset;
      t_core;
      t_periph;
      t_freeze;
      t_cgm;
      t_level;
      t_wake;
      t_alarm;
      t_mid_reset;
      report_and_stop;
   end
endmodule
